// ===== verilog/smcs_regs.svh
// register map, field positions, reset values and bit timing of the serial mode block
// assumes an 8-bit register port with a 3-bit word address
`ifndef SMCS_REGS_SVH
`define SMCS_REGS_SVH

`define SMCS_ADDR_MODE     3'h0
`define SMCS_ADDR_CTRL     3'h1
`define SMCS_ADDR_DIVISOR  3'h2
`define SMCS_ADDR_TX_DATA  3'h3
`define SMCS_ADDR_RX_DATA  3'h4
`define SMCS_ADDR_STATUS   3'h5

`define SMCS_MODE_SYNC     7
`define SMCS_MODE_FIVE     2
`define SMCS_MODE_CKS_HI   1
`define SMCS_MODE_CKS_LO   0
`define SMCS_MODE_MASK     8'h87

`define SMCS_CTRL_IRDA     6
`define SMCS_CTRL_RX_EN    5
`define SMCS_CTRL_TX_EN    4
`define SMCS_CTRL_BIT3     3
`define SMCS_CTRL_MASK     8'h78

`define SMCS_STAT_TX_EMPTY 7
`define SMCS_STAT_RX_FULL  6
`define SMCS_STAT_OVERRUN  5
`define SMCS_STAT_FRAMING  4

`define SMCS_MODE_RESET    8'h00
`define SMCS_CTRL_RESET    8'h00
`define SMCS_DIV_RESET     8'hFF

`define SMCS_CS_SYS        2'h0
`define SMCS_CS_SUB        2'h1

`define SMCS_OS_LAST       4'hF
`define SMCS_OS_MID        4'h7
`define SMCS_IR_MID        4'h1
`define SMCS_IR_PULSE      4'h3
`define SMCS_SCLK_RISE     4'h8
`define SMCS_LAST_EIGHT    3'h7
`define SMCS_LAST_FIVE     3'h4

`endif

// ===== verilog/smcs_pkg.sv
// types shared by the serial mode block
// assumes nothing beyond a SystemVerilog compiler
package smcs_pkg;
  typedef enum logic [3:0] {
    smcs_idle  = 4'b0001,
    smcs_start = 4'b0010,
    smcs_data  = 4'b0100,
    smcs_stop  = 4'b1000
  } smcs_state_type;

  typedef enum logic [1:0] {
    smcs_active    = 2'h0,
    smcs_sleep     = 2'h1,
    smcs_subactive = 2'h2,
    smcs_subsleep  = 2'h3
  } smcs_power_type;
endpackage

// ===== verilog/smcs_top.sv
// serial interface with mode and clock-source selection, async/clocked/infrared framing
// assumes power_mode and cpu_clock_half_sub come from mclk logic; serial_in, sub_clock are pins
//
// Strobed register access and the address map were decided locally.
`timescale 1ns/1ps
`include "smcs_regs.svh"

module smcs_top #(
  parameter logic IS_CHANNEL_ONE = 1'b1
) (
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  input  wire logic [2:0]              addr,
  input  wire logic [7:0]              wdata,
  input  wire logic                    wr,
  input  wire logic                    rd,
  output logic [7:0]                   rdata,
  input  wire logic                    serial_in,
  input  wire logic                    sub_clock,
  input  smcs_pkg::smcs_power_type     power_mode,
  input  wire logic                    cpu_clock_half_sub,
  output logic                         serial_out,
  output logic                         serial_clock_out,
  output logic                         serial_clock_oe
);
  import smcs_pkg::*;

  logic [7:0]     mode, ctrl, divisor, tx_buf, rx_buf;
  logic           tx_full, rx_full, overrun, framing;
  logic [7:0]     next_mode, next_ctrl, next_divisor, next_tx_buf, next_rx_buf, next_rdata;
  logic           next_tx_full, next_rx_full, next_overrun, next_framing;
  logic           sin_s1, sin_s2, sub_s1, sub_s2, sub_prev, half_toggle, os_tick;
  logic           next_half_toggle, next_os_tick, src_tick, sub_rise;
  logic [7:0]     div_count, next_div_count;
  smcs_state_type tx_state, next_tx_state, rx_state, next_rx_state;
  logic [7:0]     tx_shift, next_tx_shift, rx_shift, next_rx_shift;
  logic [2:0]     tx_count, next_tx_count, rx_count, next_rx_count;
  logic [3:0]     tx_phase, next_tx_phase, rx_phase, next_rx_phase;
  logic           sync_rx, next_sync_rx, tx_take, sync_sample, sync_done;
  logic           next_serial_out, next_sclk_out, bit_val;
  logic           rx_done, rx_ferr, rx_line, rx_sample;

  wire logic       sync_mode = mode[`SMCS_MODE_SYNC];
  wire logic       five_bit  = mode[`SMCS_MODE_FIVE];
  wire logic [1:0] clk_sel   = {mode[`SMCS_MODE_CKS_HI], mode[`SMCS_MODE_CKS_LO]};
  wire logic       rx_en     = ctrl[`SMCS_CTRL_RX_EN];
  wire logic       tx_en     = ctrl[`SMCS_CTRL_TX_EN];
  wire logic       irda      = IS_CHANNEL_ONE & ctrl[`SMCS_CTRL_IRDA] & ~sync_mode;
  // relies on software ordering control bit 3 and receive enable around it
  wire logic [2:0] last_bit  = five_bit ? `SMCS_LAST_FIVE : `SMCS_LAST_EIGHT;
  wire logic [7:0] rx_word   = five_bit ? {3'h0, rx_shift[7:3]} : rx_shift;
  wire logic [3:0] samp_pt   = irda ? `SMCS_IR_MID : `SMCS_OS_MID;

  // pin synchronisers
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sin_s1 <= 1'b1;
      sin_s2 <= 1'b1;
      sub_s1 <= 1'b0;
      sub_s2 <= 1'b0;
      sub_prev <= 1'b0;
    end else begin
      sin_s1 <= serial_in;
      sin_s2 <= sin_s1;
      sub_s1 <= sub_clock;
      sub_s2 <= sub_s1;
      sub_prev <= sub_s2;
    end
  end

  // baud source selection and divider
  always_comb begin
    sub_rise = sub_s2 & ~sub_prev;
    next_half_toggle = half_toggle ^ sub_rise;
    case (clk_sel)
      `SMCS_CS_SYS: src_tick = 1'b1;
      `SMCS_CS_SUB: src_tick = cpu_clock_half_sub & sub_rise &
                               (power_mode == smcs_subactive || power_mode == smcs_subsleep ||
                                half_toggle);
      default:      src_tick = 1'b0;
    endcase
    next_div_count = div_count;
    next_os_tick = 1'b0;
    if (src_tick) begin
      if (div_count == 8'h00) begin
        next_div_count = divisor;
        next_os_tick = 1'b1;
      end else begin
        next_div_count = div_count - 8'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      half_toggle <= 1'b0;
      div_count <= 8'h00;
      os_tick <= 1'b0;
    end else begin
      half_toggle <= next_half_toggle;
      div_count <= next_div_count;
      os_tick <= next_os_tick;
    end
  end

  // transmitter, also the bit clock master in synchronous mode
  always_comb begin
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_count = tx_count;
    next_tx_phase = tx_phase;
    next_sync_rx = sync_rx;
    tx_take = 1'b0;
    sync_sample = 1'b0;
    sync_done = 1'b0;
    if (os_tick) begin
      next_tx_phase = tx_phase + 4'h1;
    end
    case (tx_state)
      smcs_idle: begin
        next_tx_phase = 4'h0;
        if (os_tick && ((tx_full && tx_en) || (sync_mode && rx_en && !rx_full))) begin
          tx_take = tx_full & tx_en;
          next_tx_shift = tx_take ? tx_buf : 8'hFF;
          next_tx_count = 3'h0;
          next_sync_rx = sync_mode & rx_en & ~rx_full;
          next_tx_state = sync_mode ? smcs_data : smcs_start;
        end
      end
      smcs_start: begin
        if (os_tick && tx_phase == `SMCS_OS_LAST) begin
          next_tx_state = smcs_data;
        end
      end
      smcs_data: begin
        sync_sample = sync_mode & sync_rx & os_tick & (tx_phase == `SMCS_SCLK_RISE);
        if (os_tick && tx_phase == `SMCS_OS_LAST) begin
          if (tx_count == last_bit) begin
            sync_done = sync_mode & sync_rx;
            next_tx_state = sync_mode ? smcs_idle : smcs_stop;
          end else begin
            next_tx_count = tx_count + 3'h1;
            next_tx_shift = {1'b1, tx_shift[7:1]};
          end
        end
      end
      smcs_stop: begin
        if (os_tick && tx_phase == `SMCS_OS_LAST) begin
          next_tx_state = smcs_idle;
        end
      end
      default: next_tx_state = smcs_idle;
    endcase
    case (tx_state)
      smcs_start: bit_val = 1'b0;
      smcs_data:  bit_val = tx_shift[0];
      default:    bit_val = 1'b1;
    endcase
    // infrared sends a short high pulse for each zero, line low otherwise
    next_serial_out = irda ? (~bit_val & (tx_phase < `SMCS_IR_PULSE)) : bit_val;
    next_sclk_out = ~(sync_mode && tx_state == smcs_data && tx_phase < `SMCS_SCLK_RISE);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= smcs_idle;
      tx_shift <= 8'hFF;
      tx_count <= 3'h0;
      tx_phase <= 4'h0;
      sync_rx <= 1'b0;
      serial_out <= 1'b1;
      serial_clock_out <= 1'b1;
      serial_clock_oe <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      tx_shift <= next_tx_shift;
      tx_count <= next_tx_count;
      tx_phase <= next_tx_phase;
      sync_rx <= next_sync_rx;
      serial_out <= next_serial_out;
      serial_clock_out <= next_sclk_out;
      serial_clock_oe <= sync_mode;
    end
  end

  // asynchronous receiver; synchronous bits arrive through the transmitter's clock
  always_comb begin
    rx_line = irda ? ~sin_s2 : sin_s2;
    next_rx_state = rx_state;
    next_rx_count = rx_count;
    next_rx_phase = rx_phase;
    next_rx_shift = rx_shift;
    rx_sample = os_tick & (rx_phase == samp_pt);
    rx_done = sync_done;
    rx_ferr = 1'b0;
    if (os_tick) begin
      next_rx_phase = rx_phase + 4'h1;
    end
    if (sync_sample) begin
      next_rx_shift = {sin_s2, rx_shift[7:1]};
    end
    case (rx_state)
      smcs_idle: begin
        next_rx_phase = 4'h0;
        if (os_tick && rx_en && !sync_mode && !rx_line) begin
          next_rx_state = smcs_start;
        end
      end
      smcs_start: begin
        if (rx_sample && rx_line) begin
          next_rx_state = smcs_idle;
        end else if (os_tick && rx_phase == `SMCS_OS_LAST) begin
          next_rx_count = 3'h0;
          next_rx_state = smcs_data;
        end
      end
      smcs_data: begin
        if (rx_sample) begin
          next_rx_shift = {rx_line, rx_shift[7:1]};
        end
        if (os_tick && rx_phase == `SMCS_OS_LAST) begin
          next_rx_count = rx_count + 3'h1;
          if (rx_count == last_bit) begin
            next_rx_state = smcs_stop;
          end
        end
      end
      smcs_stop: begin
        if (rx_sample) begin
          rx_done = 1'b1;
          rx_ferr = ~rx_line;
          next_rx_state = smcs_idle;
        end
      end
      default: next_rx_state = smcs_idle;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rx_state <= smcs_idle;
      rx_count <= 3'h0;
      rx_phase <= 4'h0;
      rx_shift <= 8'h00;
    end else begin
      rx_state <= next_rx_state;
      rx_count <= next_rx_count;
      rx_phase <= next_rx_phase;
      rx_shift <= next_rx_shift;
    end
  end

  // register file; hardware setting a flag wins over software clearing it
  always_comb begin
    next_mode = mode;
    next_ctrl = ctrl;
    next_divisor = divisor;
    next_tx_buf = tx_buf;
    next_rx_buf = rx_buf;
    next_tx_full = tx_full & ~tx_take;
    next_rx_full = rx_full;
    next_overrun = overrun;
    next_framing = framing;
    next_rdata = 8'h00;
    if (wr) begin
      case (addr)
        `SMCS_ADDR_MODE:    next_mode = wdata & `SMCS_MODE_MASK;
        `SMCS_ADDR_CTRL:    next_ctrl = wdata & `SMCS_CTRL_MASK;
        `SMCS_ADDR_DIVISOR: next_divisor = wdata;
        `SMCS_ADDR_TX_DATA: begin
          next_tx_buf = wdata;
          next_tx_full = 1'b1;
        end
        `SMCS_ADDR_STATUS: begin
          next_overrun = overrun & ~wdata[`SMCS_STAT_OVERRUN];
          next_framing = framing & ~wdata[`SMCS_STAT_FRAMING];
        end
        default: ;
      endcase
    end
    if (rd) begin
      case (addr)
        `SMCS_ADDR_MODE:    next_rdata = mode;
        `SMCS_ADDR_CTRL:    next_rdata = ctrl;
        `SMCS_ADDR_DIVISOR: next_rdata = divisor;
        `SMCS_ADDR_TX_DATA: next_rdata = tx_buf;
        `SMCS_ADDR_RX_DATA: begin
          next_rdata = rx_buf;
          next_rx_full = 1'b0;
        end
        `SMCS_ADDR_STATUS:  next_rdata = {~tx_full, rx_full, overrun, framing, 4'h0};
        default:            next_rdata = 8'h00;
      endcase
    end
    if (rx_done) begin
      if (rx_full && !(rd && addr == `SMCS_ADDR_RX_DATA)) begin
        next_overrun = 1'b1;
      end else begin
        next_rx_buf = rx_word;
        next_rx_full = 1'b1;
        next_framing = next_framing | rx_ferr;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode <= `SMCS_MODE_RESET;
      ctrl <= `SMCS_CTRL_RESET;
      divisor <= `SMCS_DIV_RESET;
      tx_buf <= 8'h00;
      rx_buf <= 8'h00;
      tx_full <= 1'b0;
      rx_full <= 1'b0;
      overrun <= 1'b0;
      framing <= 1'b0;
      rdata <= 8'h00;
    end else begin
      mode <= next_mode;
      ctrl <= next_ctrl;
      divisor <= next_divisor;
      tx_buf <= next_tx_buf;
      rx_buf <= next_rx_buf;
      tx_full <= next_tx_full;
      rx_full <= next_rx_full;
      overrun <= next_overrun;
      framing <= next_framing;
      rdata <= next_rdata;
    end
  end
endmodule

// ===== verification/smcs_assertions.sv
// port checker for the serial mode block
// assumes mode and divisor change only through the register port
`timescale 1ns/1ps
`include "smcs_regs.svh"

module smcs_assertions (
  input wire logic       mclk,
  input wire logic       nrst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       cpu_clock_half_sub,
  input wire logic       serial_out,
  input wire logic       serial_clock_out,
  input wire logic       serial_clock_oe
);
  logic [7:0] mode_sh, next_mode_sh;
  logic       div_zero, next_div_zero;
  logic [3:0] quiet, next_quiet;
  logic       fast;
  assign fast = div_zero && mode_sh[1:0] == `SMCS_CS_SYS;
  always_comb begin
    next_mode_sh  = mode_sh;
    next_div_zero = div_zero;
    next_quiet    = wr ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    if (wr && addr == `SMCS_ADDR_MODE) next_mode_sh = wdata & `SMCS_MODE_MASK;
    if (wr && addr == `SMCS_ADDR_DIVISOR) next_div_zero = wdata == 8'h00;
  end
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      mode_sh  <= `SMCS_MODE_RESET;
      div_zero <= 1'b0;
      quiet    <= 4'h0;
    end else begin
      mode_sh  <= next_mode_sh;
      div_zero <= next_div_zero;
      quiet    <= next_quiet;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence s_low8; (!serial_clock_out) [*8]; endsequence
  sequence s_high8; serial_clock_out [*8]; endsequence
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data outside answer");
  AST_UNMAPPED: assert property (rd && addr > `SMCS_ADDR_STATUS |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_MODE_READBACK: assert property (rd && addr == `SMCS_ADDR_MODE |=> rdata == $past(mode_sh))
    else $error("mode readback wrong");
  AST_OE_SYNC: assert property (quiet > 4'h1 |-> serial_clock_oe == mode_sh[7])
    else $error("clock enable not following sync bit");
  AST_SCLK_IDLE: assert property (!mode_sh[7] && quiet > 4'h2 |-> serial_clock_out)
    else $error("bit clock moves in async mode");
  AST_SCLK_LOW8: assert property ($fell(serial_clock_out) && mode_sh[7] && fast |-> s_low8 ##1 serial_clock_out)
    else $error("bit clock low phase not 8");
  AST_SCLK_HIGH8: assert property ($rose(serial_clock_out) && mode_sh[7] && fast |-> s_high8)
    else $error("bit clock high phase short");
  AST_CKS_UNUSED: assert property (mode_sh[1] && quiet > 4'h4 |-> $stable(serial_out))
    else $error("line moves with unused source");
  AST_SUB_GATED: assert property ((mode_sh[1:0] == `SMCS_CS_SUB && !cpu_clock_half_sub && quiet > 4'h3) [*5]
    |-> $stable(serial_out))
    else $error("line moves while subclock source gated");
endmodule

bind smcs_top smcs_assertions i_chk (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .cpu_clock_half_sub(cpu_clock_half_sub),
  .serial_out(serial_out), .serial_clock_out(serial_clock_out),
  .serial_clock_oe(serial_clock_oe));

// ===== verification/smcs_peer.sv
// remote serial peer: drives the block's serial input, decodes its output
// assumes whole-cycle bit times; line idles high, low in infrared mode
`timescale 1ns/1ps

module smcs_peer (
  input  wire logic mclk,
  input  wire logic ir_mode,
  input  wire logic line_in,
  output wire logic line_out
);
  logic busy = 1'b0;
  logic level = 1'b1;
  assign line_out = busy ? level : !ir_mode;
  // a zero is a short high pulse in infrared mode
  task automatic send(input logic [7:0] d, input int nb, input int bt);
    logic b;
    for (int i = -1; i <= nb; i++) begin
      b = (i < 0) ? 1'b0 : ((i == nb) ? 1'b1 : d[i]);
      for (int c = 0; c < bt; c++) begin
        @(posedge mclk);
        busy  <= 1'b1;
        level <= ir_mode ? (!b && c < 3) : b;
      end
    end
    @(posedge mclk);
    busy <= 1'b0;
  endtask
  task automatic collect(output logic [7:0] d, output logic ok, input int nb, input int bt);
    d  = 8'h00;
    ok = 1'b0;
    for (int w = 0; w < 4000 && !ok; w++) begin
      @(negedge mclk);
      ok = line_in === 1'b0;
    end
    repeat (bt / 2) @(negedge mclk);
    for (int i = 0; i < nb; i++) begin
      repeat (bt) @(negedge mclk);
      d[i] = line_in;
    end
  endtask
endmodule

// ===== verification/smcs_top_test.sv
// self-checking bench for the serial mode block and a remote peer
// assumes divisor zero, so one oversample tick per source tick
`timescale 1ns/1ps
`include "smcs_regs.svh"

module smcs_top_test;
  import smcs_pkg::*;
  logic           mclk = 1'b0;
  logic           nrst = 1'b0;
  logic [2:0]     addr = 3'h0;
  logic [7:0]     wdata = 8'h00;
  logic           wr = 1'b0;
  logic           rd = 1'b0;
  logic           sub_clock = 1'b0;
  logic           cpu_half = 1'b1;
  logic           ir_mode = 1'b0;
  smcs_power_type power_mode = smcs_active;
  logic [7:0]     rdata;
  wire logic      serial_in;
  logic           serial_out, serial_clock_out, serial_clock_oe;
  int             failures = 0;
  int             tests_run = 0;

  always #12.5 mclk = ~mclk;
  always begin
    repeat (2) @(posedge mclk);
    sub_clock <= ~sub_clock;
  end
  smcs_top i_dut (.mclk(mclk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .serial_in(serial_in), .sub_clock(sub_clock), .power_mode(power_mode),
    .cpu_clock_half_sub(cpu_half), .serial_out(serial_out),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe));
  smcs_peer i_peer (.mclk(mclk), .ir_mode(ir_mode), .line_in(serial_out), .line_out(serial_in));

  task automatic conclude;
    $display("failures=%0d tests_run=%0d", failures, tests_run);
    if (failures == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask
  task automatic run(input logic lvl, output logic [7:0] n);
    int w;
    n = 8'h00;
    for (w = 0; w < 3000 && serial_out !== lvl; w++) @(negedge mclk);
    if (w == 3000) begin failures++; conclude(); end
    while (serial_out === lvl && n != 8'hFF) begin
      n++;
      @(negedge mclk);
    end
    @(posedge mclk);
  endtask
  task automatic quiet_for;
    logic [7:0] n;
    n = 8'h00;
    repeat (200) begin
      @(negedge mclk);
      if (serial_out === 1'b1) n++;
    end
    check(n, 8'hC8);
    @(posedge mclk);
  endtask
  task automatic frame(input int nb, input logic [7:0] tx, output logic [7:0] d);
    logic ok;
    fork
      i_peer.collect(d, ok, nb, 16);
      wr_reg(`SMCS_ADDR_TX_DATA, tx);
    join
    if (!ok) begin failures++; conclude(); end
    repeat (24) @(posedge mclk);
  endtask
  task automatic get_rx(output logic [7:0] d);
    logic [7:0] s;
    int w;
    s = 8'h00;
    for (w = 0; w < 200 && s[`SMCS_STAT_RX_FULL] !== 1'b1; w++) rd_reg(`SMCS_ADDR_STATUS, s);
    if (w == 200) begin failures++; conclude(); end
    rd_reg(`SMCS_ADDR_RX_DATA, d);
  endtask

  task automatic t_regs;
    logic [7:0] v;
    for (int a = 0; a < 8; a++) begin
      if (a == 3 || a == 4) continue;
      rd_reg(3'(a), v);
      check(v, (a == 2) ? `SMCS_DIV_RESET : ((a == 5) ? 8'h80 : 8'h00));
    end
    wr_reg(`SMCS_ADDR_MODE, 8'hFF);
    rd_reg(`SMCS_ADDR_MODE, v);
    check(v, 8'h87);
    wr_reg(`SMCS_ADDR_MODE, 8'h00);
    wr_reg(`SMCS_ADDR_CTRL, 8'h98);
    rd_reg(`SMCS_ADDR_CTRL, v);
    check(v, 8'h18);
    $display("registers done");
  endtask
  task automatic t_async_five;
    logic [7:0] v;
    wr_reg(`SMCS_ADDR_DIVISOR, 8'h00);
    wr_reg(`SMCS_ADDR_CTRL, 8'h38);
    frame(8, 8'hA5, v);
    check(v, 8'hA5);
    i_peer.send(8'h3C, 8, 16);
    get_rx(v);
    check(v, 8'h3C);
    // control bit 3 and receive enable stand before the five-bit bit
    wr_reg(`SMCS_ADDR_MODE, 8'h04);
    frame(5, 8'hF5, v);
    check(v, 8'h15);
    i_peer.send(8'hEA, 5, 16);
    get_rx(v);
    check(v, 8'h0A);
    wr_reg(`SMCS_ADDR_MODE, 8'h00);
    $display("async and five-bit done");
  endtask
  task automatic t_irda_sync;
    logic [7:0] v;
    int w;
    wr_reg(`SMCS_ADDR_CTRL, 8'h18);
    ir_mode <= 1'b1;
    wr_reg(`SMCS_ADDR_CTRL, 8'h78);
    @(posedge mclk);
    check({7'h00, serial_out}, 8'h00);
    wr_reg(`SMCS_ADDR_TX_DATA, 8'hFE);
    run(1'b1, v);
    check(v, 8'h03);
    i_peer.send(8'h5A, 8, 16);
    get_rx(v);
    check(v, 8'h5A);
    wr_reg(`SMCS_ADDR_CTRL, 8'h18);
    ir_mode <= 1'b0;
    wr_reg(`SMCS_ADDR_MODE, 8'h80);
    wr_reg(`SMCS_ADDR_TX_DATA, 8'h3C);
    for (w = 0; w < 100 && serial_clock_out !== 1'b0; w++) @(posedge mclk);
    if (w == 100) begin failures++; conclude(); end
    check({7'h00, serial_clock_oe}, 8'h01);
    repeat (140) @(posedge mclk);
    // peer idles low here, so the dummy clocked frame gathers zeros
    ir_mode <= 1'b1;
    wr_reg(`SMCS_ADDR_CTRL, 8'h38);
    get_rx(v);
    check(v, 8'h00);
    wr_reg(`SMCS_ADDR_CTRL, 8'h18);
    ir_mode <= 1'b0;
    repeat (140) @(posedge mclk);
    $display("infrared and sync done");
  endtask
  task automatic t_sub;
    logic [7:0] v;
    wr_reg(`SMCS_ADDR_MODE, 8'h01);
    for (int p = 0; p < 4; p++) begin
      power_mode <= smcs_power_type'(p);
      wr_reg(`SMCS_ADDR_TX_DATA, 8'hFF);
      run(1'b0, v);
      check(v, (p < 2) ? 8'h80 : 8'h40);
    end
    power_mode <= smcs_active;
    // let the frame in flight finish so a start bit could show while gated
    repeat (1300) @(posedge mclk);
    cpu_half <= 1'b0;
    wr_reg(`SMCS_ADDR_TX_DATA, 8'hFF);
    quiet_for();
    cpu_half <= 1'b1;
    run(1'b0, v);
    check(v, 8'h80);
    repeat (1300) @(posedge mclk);
    for (int c = 2; c < 4; c++) begin
      wr_reg(`SMCS_ADDR_MODE, 8'(c));
      wr_reg(`SMCS_ADDR_TX_DATA, 8'hFF);
      quiet_for();
    end
    $display("clock source done");
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_async_five();
    t_irda_sync();
    t_sub();
    conclude();
  end
endmodule
